// File: logic/sbps_clamp.v
/*
  Signed clamp of a value into [lo, hi].
  Assumes lo <= hi; purely combinational.
*/
module sbps_clamp #(
  parameter W = 16
) (
  input wire signed [W-1:0] val_i,
  input wire signed [W-1:0] lo_i,
  input wire signed [W-1:0] hi_i,
  output reg signed [W-1:0] val_o
);
  always @* begin
    if (val_i > hi_i) begin
      val_o = hi_i;
    end else if (val_i < lo_i) begin
      val_o = lo_i;
    end else begin
      val_o = val_i;
    end
  end
endmodule

// File: logic/sbps_consts.vh
/*
  Constants for the sensor-break and process-value scaling block.
  Assumes signed fixed-point values: percent in tenths, millivolts in hundredths.
*/
`ifndef SBPS_CONSTS_VH
`define SBPS_CONSTS_VH
`define SBPS_MODE_OFF 2'h0
`define SBPS_MODE_ON 2'h1
`define SBPS_MODE_LAT 2'h2
`define SBPS_OUT_HEAT_COOL 2'h0
`define SBPS_OUT_HEAT 2'h1
`define SBPS_OUT_COOL 2'h2
`define SBPS_IN_LINEAR 4'h9
`define SBPS_PCT_MAX 16'sd1000
`define SBPS_PCT_MIN (-16'sd1000)
`define SBPS_PCT_ZERO 16'sd0
`define SBPS_MV_MIN (-16'sd1000)
`define SBPS_MV_MAX 16'sd8000
`define SBPS_BREAK_PCT 8'd5
`define SBPS_FLASH_HALF_MS 250
`define SBPS_CLK_KHZ 10000
`define SBPS_FLASH_CYC (`SBPS_FLASH_HALF_MS * `SBPS_CLK_KHZ)
`endif

// File: logic/sbps_core.v
/*
  Sensor-break handling and process-value scaling for a process controller.
  Assumes configuration ports come from logic on core_clk_i; the front end
  delivers a signed millivolt sample with a one-cycle valid strobe.
*/
`include "sbps_consts.vh"
module sbps_core #(
  parameter FLASH_CYC = `SBPS_FLASH_CYC
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [1:0] sensor_break_mode_select_i,
  input wire [1:0] output_type_i,
  input wire [3:0] input_type_select_i,
  input wire signed [15:0] output_upper_limit_i,
  input wire signed [15:0] output_lower_limit_i,
  input wire signed [15:0] safe_value_i,
  input wire safe_value_wr_i,
  input wire signed [15:0] process_value_offset_i,
  input wire signed [15:0] linear_input_low_i,
  input wire signed [15:0] linear_input_high_i,
  input wire signed [15:0] display_range_low_i,
  input wire signed [15:0] display_range_high_i,
  input wire signed [15:0] sample_i,
  input wire sample_valid_i,
  input wire sensor_fault_i,
  input wire ack_i,
  input wire signed [15:0] control_demand_i,
  output reg signed [15:0] process_value_o,
  output reg pv_valid_o,
  output reg signed [15:0] control_output_o,
  output reg signed [15:0] safe_value_o,
  output reg signed [15:0] out_hi_o,
  output reg signed [15:0] out_lo_o,
  output reg sensor_fault_alarm_o,
  output reg alarm_beacon_o,
  output reg alarm_relay_o,
  output reg in_break_o
);
  reg signed [15:0] type_lo;
  reg signed [15:0] type_hi;
  reg signed [15:0] lim_hi;
  reg signed [15:0] lim_lo;
  wire signed [15:0] lim_hi_c;
  wire signed [15:0] lim_lo_c;
  wire signed [15:0] safe_src;
  wire signed [15:0] safe_c;
  reg signed [15:0] safe_q;
  reg break_q;
  reg alarm_q;
  reg [31:0] flash_cnt_q;
  reg flash_q;
  reg pv_valid_q;
  reg signed [15:0] pv_q;
  wire linear_sel;
  wire signed [16:0] span_in;
  wire signed [16:0] span_out;
  wire signed [16:0] margin;
  wire signed [17:0] lo_lim;
  wire signed [17:0] hi_lim;
  wire signed [17:0] s_ext;
  wire out_of_range;
  wire signed [16:0] delta;
  wire signed [33:0] prod;
  wire signed [33:0] quot;
  wire signed [33:0] scaled;
  wire signed [33:0] pv_sum;
  reg signed [15:0] pv_sat;
  wire break_now;
  reg signed [15:0] out_d;
  wire signed [16:0] span_abs;
  wire below_mv;
  wire above_mv;
  wire below_pt;
  wire above_pt;
  wire break_bad;
  wire signed [15:0] demand_c;
  reg ack_meta_q;
  reg ack_sync_q;
  reg ack_prev_q;
  wire ack_press;

  localparam [31:0] FLASH_LAST = FLASH_CYC - 1;

  // Output limits confined to what the output type allows
  always @* begin
    case (output_type_i)
      `SBPS_OUT_HEAT: begin
        type_lo = `SBPS_PCT_ZERO;
        type_hi = `SBPS_PCT_MAX;
      end
      `SBPS_OUT_COOL: begin
        type_lo = `SBPS_PCT_MIN;
        type_hi = `SBPS_PCT_ZERO;
      end
      default: begin
        type_lo = `SBPS_PCT_MIN;
        type_hi = `SBPS_PCT_MAX;
      end
    endcase
  end

  sbps_clamp #(.W(16)) u_hi_clamp (
    .val_i(output_upper_limit_i),
    .lo_i(type_lo),
    .hi_i(type_hi),
    .val_o(lim_hi_c)
  );

  sbps_clamp #(.W(16)) u_lo_clamp (
    .val_i(output_lower_limit_i),
    .lo_i(type_lo),
    .hi_i(type_hi),
    .val_o(lim_lo_c)
  );

  // Lower limit may never pass the upper one
  always @* begin
    lim_hi = lim_hi_c;
    lim_lo = (lim_lo_c > lim_hi_c) ? lim_hi_c : lim_lo_c;
  end

  // New writes are clamped too; otherwise the stored value is re-clamped
  // every cycle, so a limit change drags the safe value with it
  assign safe_src = safe_value_wr_i ? safe_value_i : safe_q;

  sbps_clamp #(.W(16)) u_safe_clamp (
    .val_i(safe_src),
    .lo_i(lim_lo),
    .hi_i(lim_hi),
    .val_o(safe_c)
  );

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      safe_q <= 16'sh0000;
    end else begin
      safe_q <= safe_c;
    end
  end

  // Linear scaling path
  assign linear_sel = (input_type_select_i == `SBPS_IN_LINEAR);
  assign span_in = {linear_input_high_i[15], linear_input_high_i}
                 - {linear_input_low_i[15], linear_input_low_i};
  assign span_out = {display_range_high_i[15], display_range_high_i}
                  - {display_range_low_i[15], display_range_low_i};
  // Magnitude of the span; the break window still needs the low point entered below the high one
  assign span_abs = (span_in < 17'sd0) ? -span_in : span_in;
  // Five percent taken as a twentieth, so no product can overflow
  assign margin = span_abs / 17'sd20;
  // Thresholds one bit wider so the margin cannot wrap them
  assign lo_lim = {linear_input_low_i[15], linear_input_low_i[15], linear_input_low_i}
                - {margin[16], margin};
  assign hi_lim = {linear_input_high_i[15], linear_input_high_i[15], linear_input_high_i}
                + {margin[16], margin};
  assign s_ext = {sample_i[15], sample_i[15], sample_i};
  // Outside the accepted -10..80 mV window
  assign below_mv = (sample_i < `SBPS_MV_MIN);
  assign above_mv = (sample_i > `SBPS_MV_MAX);
  // More than five percent of the span beyond either point
  assign below_pt = (s_ext < lo_lim);
  assign above_pt = (s_ext > hi_lim);
  assign out_of_range = below_mv || above_mv || below_pt || above_pt;
  // A front-end fault breaks any input type; the range test only the linear one
  assign break_bad = sensor_fault_i || (linear_sel && out_of_range);

  // A 17-bit difference times a 17-bit span needs the full 34-bit product
  assign delta = {sample_i[15], sample_i} - {linear_input_low_i[15], linear_input_low_i};
  assign prod = delta * span_out;
  // A zero input span would divide by zero, so the low display value is held
  assign quot = (span_in == 17'sd0) ? 34'sd0 : prod / span_in;
  // Direct sensor inputs pass through unscaled
  assign scaled = linear_sel ? (quot + {{18{display_range_low_i[15]}}, display_range_low_i})
                             : {{18{sample_i[15]}}, sample_i};
  assign pv_sum = scaled + {{18{process_value_offset_i[15]}}, process_value_offset_i};
  // Saturate rather than wrap, so an overrange reading cannot flip sign
  always @* begin
    if (pv_sum > 34'sd32767) begin
      pv_sat = 16'sh7fff;
    end else if (pv_sum < -34'sd32768) begin
      pv_sat = 16'sh8000;
    end else begin
      pv_sat = pv_sum[15:0];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pv_q <= 16'sh0000;
      pv_valid_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      pv_valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        pv_q <= pv_sat;
        break_q <= break_bad;
      end else if (sensor_fault_i) begin
        break_q <= 1'b1;
      end
    end
  end

  assign break_now = break_q;

  // Operator key arrives off-clock: two flops, then a third for the press edge.
  // Only a fresh press counts, so a key held through the fault clears nothing
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_i;
      ack_sync_q <= ack_meta_q;
      ack_prev_q <= ack_sync_q;
    end
  end

  assign ack_press = ack_sync_q & ~ack_prev_q;

  // Alarm state per mode
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else begin
      case (sensor_break_mode_select_i)
        `SBPS_MODE_ON: begin
          alarm_q <= break_now;
        end
        `SBPS_MODE_LAT: begin
          // Set wins; acknowledge only counts once the fault is gone
          if (break_now) begin
            alarm_q <= 1'b1;
          end else if (ack_press) begin
            alarm_q <= 1'b0;
          end
        end
        default: begin
          alarm_q <= 1'b0;
        end
      endcase
    end
  end

  // Beacon flash rate divider; runs only while an alarm stands
  always @(posedge core_clk_i) begin
    if (rst_i || !alarm_q) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= FLASH_LAST) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  // Normal demand held inside the effective limits
  sbps_clamp #(.W(16)) u_demand_clamp (
    .val_i(control_demand_i),
    .lo_i(lim_lo),
    .hi_i(lim_hi),
    .val_o(demand_c)
  );

  // Output selection in sensor break
  always @* begin
    out_d = demand_c;
    if (break_now) begin
      case (sensor_break_mode_select_i)
        `SBPS_MODE_ON,
        `SBPS_MODE_LAT: begin
          out_d = safe_q;
        end
        default: begin
          // Safe value ignored with break handling off
          out_d = lim_hi;
        end
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      process_value_o <= 16'sh0000;
      pv_valid_o <= 1'b0;
      control_output_o <= 16'sh0000;
      safe_value_o <= 16'sh0000;
      out_hi_o <= 16'sh0000;
      out_lo_o <= 16'sh0000;
      sensor_fault_alarm_o <= 1'b0;
      alarm_beacon_o <= 1'b0;
      alarm_relay_o <= 1'b0;
      in_break_o <= 1'b0;
    end else begin
      process_value_o <= pv_q;
      pv_valid_o <= pv_valid_q;
      control_output_o <= out_d;
      safe_value_o <= safe_q;
      out_hi_o <= lim_hi;
      out_lo_o <= lim_lo;
      sensor_fault_alarm_o <= alarm_q;
      // First half-period lit, so the beacon shows at once
      alarm_beacon_o <= alarm_q & ~flash_q;
      alarm_relay_o <= alarm_q;
      in_break_o <= break_now;
    end
  end
endmodule

// File: testbench/sbps_core_bench.sv
/*
  Self-checking bench for sbps_core.
  Assumes the front end model and a 10 MHz clock.
*/
module sbps_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, swr = 0, ack = 0;
  logic [1:0] mode = 1, otype = 0;
  logic [3:0] itype = 4'h9;
  logic signed [15:0] ohi = 1000, olo = -1000, safe = 0, ofs = 0, dem = 0;
  logic signed [15:0] llo = 400, lhi = 2000, rlo = 20, rhi = 5000;
  wire signed [15:0] smp, pv, cout, sv, ehi, elo;
  wire sval, sflt, pvv, alarm_beacon, bcn, rly, brk;
  int bad_count = 0, cmp_count = 0;
  int bs[4] = '{319, 320, 2081, 2080};
  bit be[4] = '{1, 0, 1, 0};
  always #50 clk = ~clk;
  sbps_front_end sbps_front_end_inst (.core_clk_i(clk), .sample_o(smp),
    .sample_valid_o(sval), .sensor_fault_o(sflt));
  sbps_core #(.FLASH_CYC(4)) sbps_core_inst (.core_clk_i(clk), .rst_i(rst),
    .sensor_break_mode_select_i(mode), .output_type_i(otype), .input_type_select_i(itype),
    .output_upper_limit_i(ohi), .output_lower_limit_i(olo), .safe_value_i(safe),
    .safe_value_wr_i(swr), .process_value_offset_i(ofs), .linear_input_low_i(llo),
    .linear_input_high_i(lhi), .display_range_low_i(rlo), .display_range_high_i(rhi),
    .sample_i(smp), .sample_valid_i(sval), .sensor_fault_i(sflt), .ack_i(ack),
    .control_demand_i(dem), .process_value_o(pv), .pv_valid_o(pvv),
    .control_output_o(cout), .safe_value_o(sv), .out_hi_o(ehi), .out_lo_o(elo),
    .sensor_fault_alarm_o(alarm_beacon), .alarm_beacon_o(bcn), .alarm_relay_o(rly), .in_break_o(brk));
  task chk(input logic signed [15:0] got, input logic signed [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task snd(input logic signed [15:0] s, input logic f, input int n);
    sbps_front_end_inst.send(s, f);
    wt(n);
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    wt(4);
    rst = 0;
    snd(400, 0, 1); chk({15'h0, pvv}, 16'sh1);
    wt(1); chk(pv, 20);
    snd(2000, 0, 2); chk(pv, 5000);
    ofs = 7;
    snd(1200, 0, 2); chk(pv, 2517);
    itype = 4'h0;
    snd(123, 0, 2); chk(pv, 130);
    itype = 4'h9;
    for (int i = 0; i < 4; i++) begin
      snd(bs[i], 0, 2); chk({15'h0, brk}, {15'h0, be[i]});
    end
    llo = 0;
    lhi = 8000;
    snd(8300, 0, 2); chk({15'h0, brk}, 16'sh1);
    snd(-300, 0, 2); chk({15'h0, brk}, 16'sh0);
    llo = 400;
    lhi = 2000;
    mode = 2;
    safe = 300;
    swr = 1;
    wt(1);
    swr = 0;
    snd(1000, 1, 3); chk(cout, 300);
    chk({alarm_beacon, rly, bcn}, 16'sh7);
    ack = 1;
    wt(2);
    ack = 0;
    chk({15'h0, alarm_beacon}, 16'sh1);
    wt(2); chk({15'h0, bcn}, 16'sh0);
    snd(1000, 0, 4); chk({15'h0, alarm_beacon}, 16'sh1);
    ack = 1;
    wt(1);
    ack = 0;
    wt(3); chk({15'h0, alarm_beacon}, 16'sh0);
    mode = 1;
    snd(1000, 1, 3); chk({15'h0, alarm_beacon}, 16'sh1);
    snd(1000, 0, 4); chk({15'h0, alarm_beacon}, 16'sh0);
    mode = 0;
    snd(1000, 1, 3); chk({15'h0, alarm_beacon}, 16'sh0);
    chk(cout, 1000);
    snd(1000, 0, 2);
    olo = 400;
    wt(3); chk(sv, 400);
    olo = -1000;
    ohi = 200;
    wt(3); chk(sv, 200);
    otype = 1;
    ohi = 1000;
    olo = -500;
    wt(3); chk(elo, 0);
    otype = 2;
    wt(3); chk(ehi, 0);
    wrap_up;
  end
endmodule

// File: testbench/sbps_core_sva.sv
/*
  Port-level checker for sbps_core.
  Assumes one clock domain and synchronous active-high reset.
*/
`include "sbps_consts.vh"
module sbps_core_sva (
  input wire core_clk_i,
  input wire rst_i,
  input wire [1:0] sensor_break_mode_select_i,
  input wire [1:0] output_type_i,
  input wire sample_valid_i,
  input wire ack_i,
  input wire signed [15:0] control_output_o,
  input wire signed [15:0] safe_value_o,
  input wire signed [15:0] out_hi_o,
  input wire signed [15:0] out_lo_o,
  input wire pv_valid_o,
  input wire sensor_fault_alarm_o,
  input wire alarm_beacon_o,
  input wire alarm_relay_o,
  input wire in_break_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire md_off = sensor_break_mode_select_i == `SBPS_MODE_OFF;
  wire md_on = sensor_break_mode_select_i == `SBPS_MODE_ON;
  wire md_lat = sensor_break_mode_select_i == `SBPS_MODE_LAT;
  // Output and alarm lag the mode select and the alarm lags the break flag, so require both to settle first
  sequence s_brk_safe; ((md_on || md_lat) && in_break_o)[*3]; endsequence
  sequence s_brk_off; (md_off && in_break_o)[*3]; endsequence
  sequence s_lat_noack; (md_lat && sensor_fault_alarm_o && !ack_i)[*4]; endsequence
  sequence s_on_clear; (md_on && !in_break_o)[*4]; endsequence
  AST_PV_LAT: assert property (sample_valid_i |-> ##2 pv_valid_o)
    else $error("pv_valid_o late");
  AST_RELAY: assert property (alarm_relay_o == sensor_fault_alarm_o)
    else $error("relay differs from alarm");
  AST_BEACON: assert property ($rose(sensor_fault_alarm_o) |-> alarm_beacon_o)
    else $error("beacon dark at alarm");
  AST_LAT_HOLD: assert property (s_lat_noack |=> sensor_fault_alarm_o)
    else $error("latched alarm dropped");
  AST_LAT_BRK: assert property (md_lat && in_break_o |=> sensor_fault_alarm_o)
    else $error("alarm off in latched break");
  AST_ON_CLEAR: assert property (s_on_clear |-> !sensor_fault_alarm_o)
    else $error("alarm stuck");
  AST_SAFE_OUT: assert property (s_brk_safe |-> control_output_o == safe_value_o)
    else $error("output not safe value");
  AST_OFF: assert property (s_brk_off |->
    control_output_o == out_hi_o && !sensor_fault_alarm_o)
    else $error("off mode break wrong");
  AST_CLAMP: assert property (($stable(out_hi_o) && $stable(out_lo_o))[*3] |->
    safe_value_o >= out_lo_o && safe_value_o <= out_hi_o)
    else $error("safe value out of limits");
  AST_HEAT: assert property ((output_type_i == `SBPS_OUT_HEAT)[*3] |->
    out_lo_o >= 16'sd0 && out_hi_o <= 16'sd1000)
    else $error("heat limits");
endmodule
bind sbps_core sbps_core_sva sbps_core_sva_inst (.core_clk_i, .rst_i,
  .sensor_break_mode_select_i, .output_type_i, .sample_valid_i, .ack_i,
  .control_output_o, .safe_value_o, .out_hi_o, .out_lo_o, .pv_valid_o,
  .sensor_fault_alarm_o, .alarm_beacon_o, .alarm_relay_o, .in_break_o);

// File: testbench/sbps_front_end.sv
/*
  Sensor front end model: one-cycle sample strobe and level fault flag.
  Assumes the caller is at a falling clock edge.
*/
module sbps_front_end (
  input wire core_clk_i,
  output logic signed [15:0] sample_o,
  output logic sample_valid_o,
  output logic sensor_fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sample_o = 16'sh0;
    sample_valid_o = 1'b0;
    sensor_fault_o = 1'b0;
  end
  task send(input logic signed [15:0] v, input logic f);
    sample_o = v;
    sample_valid_o = 1'b1;
    sensor_fault_o = f;
    @(negedge core_clk_i);
    sample_valid_o = 1'b0;
    // Word not held after the strobe; inverted so stale use shows
    sample_o = ~v;
  endtask
endmodule
